/* File: bench/sfrp_host_model.sv */
`timescale 1ns/1ps
// ==========================================================
// host controller model, spi mode 0, 64 ns serial clock
module sfrp_host_model
(
    input  wire [3:0] dq,
    output reg        cs_n,
    output reg        sclk,
    output reg  [3:0] hdq,
    output reg  [3:0] hoe
);
    reg [7:0] rx [0:63];

    // idle link, clock parked low
    initial
    begin
        cs_n = 1'b1;
        sclk = 1'b0;
        hdq = 4'h0;
        hoe = 4'h0;
    end

    // one clock: lanes set while low, sampled at the rise
    task tick(input [3:0] v, input [3:0] e, output [3:0] s);
    begin
        hdq = v;
        hoe = e;
        #32;
        sclk = 1'b1;
        s = dq;
        #32;
        sclk = 1'b0;
    end
    endtask

    task frame(input [7:0] op, input [2:0] lc, input [23:0] a,
               input [2:0] la, input [4:0] nd, input [2:0] ld,
               input integer nb, input integer xc);
        reg [31:0] sh;
        reg [3:0]  s;
        reg [7:0]  r;
        integer    n;
        integer    k;
    begin
        cs_n = 1'b0;
        #4;
        sh = {op, a};
        for (n = 0; n < 8; n = n + lc)
        begin
            tick(sh[31:28] >> (4 - lc), (4'h1 << lc) - 4'h1, s);
            sh = sh << lc;
        end
        for (n = 0; n < 24; n = n + la)
        begin
            tick(sh[31:28] >> (4 - la), (4'h1 << la) - 4'h1, s);
            sh = sh << la;
        end
        repeat (nd) tick(4'h0, 4'h0, s);
        for (k = 0; k < nb; k = k + 1)
        begin
            r = 8'h00;
            for (n = 0; n < 8; n = n + ld)
            begin
                tick(4'h0, 4'h0, s);
                // undriven lanes float high, keep only the data lanes
                r = (r << ld) | ((ld == 3'h1) ? {7'h00, s[1]} :
                    {4'h0, s & ((4'h1 << ld) - 4'h1)});
            end
            rx[k] = r;
        end
        repeat (xc) tick(4'h0, 4'h0, s);
        #8;
        cs_n = 1'b1;
        #40;
    end
    endtask
endmodule // sfrp_host_model

/* File: bench/sfrp_read_checker.sv */
`timescale 1ns/1ps
// ==========================================================
// read path checker on the top ports
module sfrp_read_checker
(
    input wire        clk,
    input wire        rstn,
    input wire        cs_n,
    input wire        sclk,
    input wire [1:0]  proto,
    input wire [3:0]  dq_out,
    input wire [3:0]  dq_oe,
    input wire [23:0] mem_addr,
    input wire        mem_rd
);
    reg        sclk_q;
    reg [3:0]  fall_q;
    reg        seen_q;
    reg [10:0] last_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    // cycles since a serial clock fall, last fetched address
    always @(posedge clk or negedge rstn)
        if (!rstn)
        begin
            sclk_q <= 1'b0;
            fall_q <= 4'hF;
            seen_q <= 1'b0;
            last_q <= 11'h000;
        end
        else
        begin
            sclk_q <= sclk;
            fall_q <= (sclk_q && !sclk) ? 4'h0 :
                      (fall_q == 4'hF) ? fall_q : fall_q + 4'h1;
            seen_q <= cs_n ? 1'b0 : (seen_q | mem_rd);
            last_q <= mem_rd ? mem_addr[10:0] : last_q;
        end

    sequence cs_idle;
        cs_n [*7];
    endsequence
    sequence out_moved;
        $changed(dq_out) && (|dq_oe) && $past(|dq_oe);
    endsequence

    reset_quiet_a: assert property ($rose(rstn) |-> dq_oe == 4'h0
        && !mem_rd && mem_addr == 24'h00_0000) else $error("drive after reset");
    release_drive_a: assert property (cs_idle |-> dq_oe == 4'h0)
        else $error("drive with select high");
    oe_legal_a: assert property (dq_oe inside {4'h0, 4'h2, 4'h3, 4'hF})
        else $error("illegal lane enable");
    width_fixed_a: assert property ($changed(dq_oe) |->
        dq_oe == 4'h0 || $past(dq_oe) == 4'h0) else $error("lane width moved");
    quad_lanes_a: assert property (proto == 2'h2 && |dq_oe |->
        dq_oe == 4'hF) else $error("quad not on four lanes");
    dual_lanes_a: assert property (proto == 2'h1 && |dq_oe |->
        dq_oe == 4'h3) else $error("dual not on two lanes");
    rd_pulse_a: assert property (mem_rd |=> !mem_rd)
        else $error("fetch strobe too long");
    addr_step_a: assert property (mem_rd && seen_q |->
        mem_addr[10:0] == last_q + 11'h001) else $error("address not stepped");
    out_timing_a: assert property (out_moved |-> fall_q <= 4'h8)
        else $error("data moved away from clock fall");
endmodule // sfrp_read_checker

bind sfrp_top sfrp_read_checker u_chk (.clk(clk), .rstn(rstn), .cs_n(cs_n),
    .sclk(sclk), .proto(proto), .dq_out(dq_out), .dq_oe(dq_oe),
    .mem_addr(mem_addr), .mem_rd(mem_rd));

/* File: bench/tb_serial_flash_read_path.sv */
`timescale 1ns/1ps
// ==========================================================
// testbench for the read path
module tb_serial_flash_read_path;
    localparam [55:0] OPS = 56'h03_0B3B_BB6B_EB5A;
    reg         clk;
    reg         rstn;
    reg  [1:0]  proto;
    reg  [4:0]  dummy_cfg;
    reg  [7:0]  mem_data;
    reg         oe_seen;
    reg  [31:0] rs;
    wire        cs_n;
    wire        sclk;
    wire [3:0]  hdq;
    wire [3:0]  hoe;
    wire [3:0]  dq_out;
    wire [3:0]  dq_oe;
    wire [3:0]  dq;
    wire [23:0] mem_addr;
    wire        mem_rd;
    integer     failures;
    integer     samples_checked;
    integer     p;
    integer     o;

    // wire level, pulled up when released
    assign dq = (dq_oe & dq_out) | (hoe & hdq) | ~(dq_oe | hoe);

    sfrp_top u_dut (.clk(clk), .rstn(rstn), .cs_n(cs_n), .sclk(sclk),
        .dq_in(dq), .dq_out(dq_out), .dq_oe(dq_oe), .proto(proto),
        .dummy_cfg(dummy_cfg), .mem_addr(mem_addr), .mem_rd(mem_rd),
        .mem_data(mem_data));
    sfrp_host_model u_host (.dq(dq), .cs_n(cs_n), .sclk(sclk), .hdq(hdq),
        .hoe(hoe));

    // clock, array model and drive monitor
    always #2 clk = ~clk;
    always @(posedge clk)
        if (mem_rd)
            mem_data <= #1 mfun(mem_addr);
    always @(posedge clk)
        if (|dq_oe)
            oe_seen <= 1'b1;

    function [7:0] mfun(input [23:0] a);
        mfun = a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h5A;
    endfunction

    function [31:0] nxt(input [31:0] x);
        reg [31:0] y;
    begin
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        nxt = y ^ (y << 5);
    end
    endfunction

    // known table bytes, top bit marks a checked place
    function [8:0] tbl(input [10:0] a);
        case (a)
            11'h000: tbl = 9'h153;
            11'h001: tbl = 9'h146;
            11'h034, 11'h035, 11'h036, 11'h040: tbl = 9'h1FF;
            11'h037: tbl = 9'h107;
            11'h038: tbl = 9'h129;
            11'h039, 11'h04B: tbl = 9'h1EB;
            11'h03A, 11'h03E: tbl = 9'h127;
            11'h03B: tbl = 9'h16B;
            11'h03C: tbl = 9'h108;
            11'h03D: tbl = 9'h13B;
            11'h03F, 11'h047: tbl = 9'h1BB;
            11'h046: tbl = 9'h128;
            11'h04A: tbl = 9'h12A;
            11'h04C: tbl = 9'h10C;
            11'h04D: tbl = 9'h120;
            11'h04E: tbl = 9'h110;
            11'h04F: tbl = 9'h1D8;
            11'h050, 11'h051, 11'h052, 11'h053: tbl = 9'h100;
            default: tbl = 9'h000;
        endcase
    endfunction

    // accepted flag, opcode, address and data lanes, dummies
    function [14:0] cfg(input [1:0] p, input [7:0] op, input [4:0] dc);
        reg [2:0] w;
        reg [4:0] d;
        reg       ok;
    begin
        w = (p == 2'h2) ? 3'h4 : (p == 2'h1) ? 3'h2 : 3'h1;
        d = (p == 2'h2) ? 5'h0A : 5'h08;
        ok = p != 2'h3 && (p == 2'h0 || op == 8'h0B || op == 8'h5A
             || (p == 2'h1 && (op == 8'h3B || op == 8'hBB))
             || (p == 2'h2 && (op == 8'h6B || op == 8'hEB)));
        if (p == 2'h0)
            d = (op == 8'h03) ? 5'h00 : (op == 8'hEB) ? 5'h09 :
                (op == 8'hBB || op == 8'h6B) ? 5'h07 : 5'h08;
        if (dc != 5'h00 && op != 8'h03 && op != 8'h5A)
            d = dc;
        if (p != 2'h0)
            cfg = {ok, w, w, w, d};
        else
            cfg = {ok, 3'h1, (op == 8'hBB) ? 3'h2 : (op == 8'hEB) ? 3'h4 :
                3'h1, (op == 8'h3B || op == 8'hBB) ? 3'h2 : (op == 8'h6B
                || op == 8'hEB) ? 3'h4 : 3'h1, d};
    end
    endfunction

    task chk(input [63:0] nm, input [7:0] e, input [7:0] g);
    begin
        samples_checked = samples_checked + 1;
        if (e !== g)
        begin
            failures = failures + 1;
            $display("unexpected %0s exp %h got %h", nm, e, g);
        end
    end
    endtask

    task run(input [1:0] p, input [7:0] op, input [4:0] dc,
             input [23:0] a, input integer nb, input integer xc);
        reg [14:0] c;
        reg [8:0]  t;
        integer    k;
    begin
        @(posedge clk);
        #1;
        proto = p;
        dummy_cfg = dc;
        oe_seen = 1'b0;
        c = cfg(p, op, dc);
        repeat (4) @(posedge clk);
        #1;
        u_host.frame(op, c[13:11], a, c[10:8], c[4:0], c[7:5], nb, xc);
        chk("lanes on", {7'h00, c[14]}, {7'h00, oe_seen});
        chk("released", 8'h00, {4'h0, dq_oe});
        for (k = 0; k < nb && c[14]; k = k + 1)
        begin
            t = (op == 8'h5A) ? tbl(a[10:0] + k[10:0]) :
                {1'b1, mfun(a + k[23:0])};
            if (t[8])
                chk("data", t[7:0], u_host.rx[k]);
        end
    end
    endtask

    task give_verdict;
    begin
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    end
    endtask

    // bounded run time
    initial
    begin
        repeat (100000) @(posedge clk);
        failures = failures + 1;
        give_verdict;
    end

    // main sequence
    initial
    begin
        clk = 1'b0;
        rstn = 1'b0;
        proto = 2'h0;
        dummy_cfg = 5'h00;
        mem_data = 8'h00;
        oe_seen = 1'b0;
        failures = 0;
        samples_checked = 0;
        rs = 32'h0000_005F;
        repeat (2) @(posedge clk);
        #1;
        rstn = 1'b1;
        repeat (4) @(posedge clk);
        for (p = 0; p < 4; p = p + 1)
            for (o = 0; o < 7; o = o + 1)
            begin
                rs = nxt(rs);
                run(p, OPS[55 - 8 * o -: 8], 5'h00, rs[23:0], 3, 0);
            end
        run(2'h0, 8'h03, 5'h00, 24'hFF_FFFE, 4, 0);
        run(2'h0, 8'h03, 5'h05, 24'h12_3456, 2, 0);
        run(2'h0, 8'h0B, 5'h05, 24'h65_4321, 2, 0);
        run(2'h0, 8'h5A, 5'h00, 24'h00_0034, 32, 0);
        run(2'h1, 8'h5A, 5'h00, 24'h00_0040, 20, 0);
        run(2'h2, 8'h5A, 5'h00, 24'h00_07FE, 4, 0);
        run(2'h0, 8'h03, 5'h00, 24'h00_0FF0, 1, 3);
        for (o = 0; o < 10; o = o + 1)
        begin
            rs = nxt(rs);
            run(rs[25:24], OPS[55 - 8 * (rs[30:28] % 7) -: 8], 5'h00,
                rs[23:0], 1 + rs[27:26], 0);
        end
        give_verdict;
    end
endmodule // tb_serial_flash_read_path

/* File: core/sfrp_disc_rom.v */
`timescale 1ns/1ps
`include "sfrp_map.vh"

module sfrp_disc_rom
(
    input  wire [10:0] addr,
    output reg  [7:0]  data
);

// ==========================================================
// table image
// header, unused fill, then the parameter table proper
localparam [8*`SFRP_T_BYTES-1:0] IMG =
{
    `SFRP_T_HDR,
    {`SFRP_T_FILLN{`SFRP_ERASED}},
    `SFRP_T_PARM,
    `SFRP_T_DENS,
    `SFRP_T_FR4,
    `SFRP_T_FR2,
    `SFRP_T_SUP,
    `SFRP_T_FRX,
    `SFRP_T_ERS
};

wire [10:0] idx = `SFRP_T_END - 11'h001 - addr;

// ==========================================================
// lookup
// addresses past the image read as erased bytes
always @*
begin
    if (addr < `SFRP_T_END)
        data = IMG[idx*8 +: 8];
    else
        data = `SFRP_ERASED;
end

endmodule // sfrp_disc_rom

/* File: core/sfrp_map.vh */
`ifndef SFRP_MAP_VH
`define SFRP_MAP_VH

// ==========================================================
// protocol select on the proto input
`define SFRP_PROTO_EXT   2'h0
`define SFRP_PROTO_DUAL  2'h1
`define SFRP_PROTO_QUAD  2'h2

// ==========================================================
// read opcodes
`define SFRP_OP_READ     8'h03
`define SFRP_OP_FAST     8'h0B
`define SFRP_OP_DOUT     8'h3B
`define SFRP_OP_DIO      8'hBB
`define SFRP_OP_QOUT     8'h6B
`define SFRP_OP_QIO      8'hEB
`define SFRP_OP_DISC     8'h5A

// ==========================================================
// field lengths in bits and lane counts
`define SFRP_CMD_BITS    5'h08
`define SFRP_ADDR_BITS   5'h18
`define SFRP_BYTE_BITS   4'h8
`define SFRP_CNT_ZERO    5'h00
`define SFRP_LN1         3'h1
`define SFRP_LN2         3'h2
`define SFRP_LN4         3'h4

// ==========================================================
// dummy clock counts per command and protocol
`define SFRP_DUM_NONE    5'h00
`define SFRP_DUM_ONE     5'h01
`define SFRP_DUM_FAST    5'h08
`define SFRP_DUM_DOUT    5'h08
`define SFRP_DUM_DIO     5'h07
`define SFRP_DUM_QOUT    5'h07
`define SFRP_DUM_QIO     5'h09
`define SFRP_DUM_DUAL    5'h08
`define SFRP_DUM_QUAD    5'h0A
`define SFRP_DUM_DISC    5'h08
`define SFRP_DUM_DISCQ   5'h0A

// ==========================================================
// output enables per lane width
`define SFRP_OE_OFF      4'h0
`define SFRP_OE_X1       4'h2
`define SFRP_OE_X2       4'h3
`define SFRP_OE_X4       4'hF

// ==========================================================
// address handling
`define SFRP_ADDR_ZERO   24'h00_0000
`define SFRP_ADDR_ONE    24'h00_0001
`define SFRP_DISC_MASK   24'h00_07FF

// ==========================================================
// discovery table image, lowest address in the top byte
`define SFRP_T_HDR   128'h5346_4450_0001_00FF_0000_0109_3000_00FF
`define SFRP_T_PARM  32'hE520_F1FF
`define SFRP_T_DENS  32'hFFFF_FF07
`define SFRP_T_FR4   32'h29EB_276B
`define SFRP_T_FR2   32'h083B_27BB
`define SFRP_T_SUP   32'hFFFF_FFFF
`define SFRP_T_FRX   64'hFFFF_28BB_FFFF_2AEB
`define SFRP_T_ERS   64'h0C20_10D8_0000_0000
`define SFRP_T_FILLN 32
`define SFRP_T_BYTES 84
`define SFRP_T_END   11'h054
`define SFRP_ERASED  8'hFF

`endif

/* File: core/sfrp_top.v */
`timescale 1ns/1ps
`include "sfrp_map.vh"

// What this block does
// - memory reads carry a 24-bit byte address, bits 23 to 0
// - address bits are sampled on serial clock rise with select low
// - address steps by one after every output byte, any start
// - select rising ends the read and stops output drive on the third clock edge after
// - fast reads put dummy clocks between address and data
// - each protocol accepts only its own subset of read commands
// - opcode, address and data lanes follow command and protocol
// - table 39h holds 1-4-4 opcode, 38h its dummy and mode counts
// - table 3Bh holds 1-1-4 opcode, 3Ah its dummy and mode counts
// - table 3Dh holds 1-1-2 opcode, 3Ch dummy and zero mode count
// - table 3Fh holds 1-2-2 opcode, 3Eh its dummy and mode counts
// - table 47h holds 2-2-2 opcode, 46h its dummy and mode counts
// - table 4Bh holds 4-4-4 opcode, 4Ah its dummy and mode counts
// - table 40h flags 2-2-2 and 4-4-4 support, all bits one
// - erase types 1 and 2 listed, types 3 and 4 read zero
// - table 34h to 37h hold density minus one, low byte first
// - table read uses 8 or 10 dummies and wraps at 2048 bytes
module sfrp_top
(
    input  wire        clk,
    input  wire        rstn,
    input  wire        cs_n,
    input  wire        sclk,
    input  wire [3:0]  dq_in,
    output reg  [3:0]  dq_out,
    output reg  [3:0]  dq_oe,
    input  wire [1:0]  proto,
    input  wire [4:0]  dummy_cfg,
    output reg  [23:0] mem_addr,
    output reg         mem_rd,
    input  wire [7:0]  mem_data
);

// ==========================================================
// states
localparam [5:0] ST_IDLE  = 6'b00_0001;
localparam [5:0] ST_CMD   = 6'b00_0010;
localparam [5:0] ST_ADDR  = 6'b00_0100;
localparam [5:0] ST_DUMMY = 6'b00_1000;
localparam [5:0] ST_DATA  = 6'b01_0000;
localparam [5:0] ST_SKIP  = 6'b10_0000;

// ==========================================================
// declarations
reg  [5:0]  sync1_q;
reg  [5:0]  sync2_q;
reg         sclk_prev_q;
reg  [5:0]  state_q;
reg  [23:0] sh_q;
reg  [4:0]  bit_cnt_q;
reg  [2:0]  aln_q;
reg  [2:0]  dln_q;
reg  [4:0]  dum_q;
reg         disc_q;
reg  [7:0]  buf_q;
reg         fetch_q;
reg  [7:0]  out_sh_q;
reg  [3:0]  left_q;
reg  [2:0]  cln;
reg         dec_ok;
reg  [2:0]  dec_aln;
reg  [2:0]  dec_dln;
reg  [4:0]  dec_dum;
reg         dec_disc;
reg  [2:0]  in_ln;
reg  [23:0] sh_d;
reg  [4:0]  cnt_d;
reg  [23:0] addr_nx;
wire        cs_s;
wire        sclk_s;
wire [3:0]  dq_s;
wire        rise;
wire        fall;
wire [7:0]  rom_data;

// ==========================================================
// pin synchronisers
// select, clock and data share one two-stage path so that
// their relative timing is kept
always @(posedge clk or negedge rstn)
begin
    if (!rstn)
    begin
        sync1_q     <= 6'h20;
        sync2_q     <= 6'h20;
        sclk_prev_q <= 1'b0;
    end
    else
    begin
        sync1_q     <= {cs_n, sclk, dq_in};
        sync2_q     <= sync1_q;
        sclk_prev_q <= sync2_q[4];
    end
end

assign cs_s   = sync2_q[5];
assign sclk_s = sync2_q[4];
assign dq_s   = sync2_q[3:0];

// serial clock edges, only while selected
assign rise = sclk_s & ~sclk_prev_q & ~cs_s;
assign fall = ~sclk_s & sclk_prev_q & ~cs_s;

// ==========================================================
// discovery table
sfrp_disc_rom u_rom
(
    .addr (mem_addr[10:0]),
    .data (rom_data)
);

// ==========================================================
// helpers
// next output group, msb on the highest lane
function [3:0] out_grp;
    input [7:0] b;
    input [2:0] ln;
    begin
        case (ln)
            `SFRP_LN2: out_grp = {2'b00, b[7:6]};
            `SFRP_LN4: out_grp = b[7:4];
            default:   out_grp = {2'b00, b[7], 1'b0};
        endcase
    end
endfunction

// lane enables for a data width
function [3:0] oe_of;
    input [2:0] ln;
    begin
        case (ln)
            `SFRP_LN2: oe_of = `SFRP_OE_X2;
            `SFRP_LN4: oe_of = `SFRP_OE_X4;
            default:   oe_of = `SFRP_OE_X1;
        endcase
    end
endfunction

// ==========================================================
// opcode lanes by protocol
// opcode lane count
always @*
begin
    case (proto)
        `SFRP_PROTO_DUAL: cln = `SFRP_LN2;
        `SFRP_PROTO_QUAD: cln = `SFRP_LN4;
        default:          cln = `SFRP_LN1;
    endcase
end

// ==========================================================
// command decode on the assembled opcode
always @*
begin
    dec_ok   = 1'b0;
    dec_aln  = `SFRP_LN1;
    dec_dln  = `SFRP_LN1;
    dec_dum  = `SFRP_DUM_NONE;
    dec_disc = 1'b0;
    case (proto)
        `SFRP_PROTO_EXT:
        begin
            case (sh_d[7:0])
                `SFRP_OP_READ: dec_ok = 1'b1;
                `SFRP_OP_FAST:
                begin
                    dec_ok  = 1'b1;
                    dec_dum = `SFRP_DUM_FAST;
                end
                `SFRP_OP_DOUT:
                begin
                    dec_ok  = 1'b1;
                    dec_dln = `SFRP_LN2;
                    dec_dum = `SFRP_DUM_DOUT;
                end
                `SFRP_OP_DIO:
                begin
                    dec_ok  = 1'b1;
                    dec_aln = `SFRP_LN2;
                    dec_dln = `SFRP_LN2;
                    dec_dum = `SFRP_DUM_DIO;
                end
                `SFRP_OP_QOUT:
                begin
                    dec_ok  = 1'b1;
                    dec_dln = `SFRP_LN4;
                    dec_dum = `SFRP_DUM_QOUT;
                end
                `SFRP_OP_QIO:
                begin
                    dec_ok  = 1'b1;
                    dec_aln = `SFRP_LN4;
                    dec_dln = `SFRP_LN4;
                    dec_dum = `SFRP_DUM_QIO;
                end
                `SFRP_OP_DISC:
                begin
                    dec_ok   = 1'b1;
                    dec_dum  = `SFRP_DUM_DISC;
                    dec_disc = 1'b1;
                end
                default: dec_ok = 1'b0;
            endcase
        end
        // dual accepts fast, dual out, dual io
        `SFRP_PROTO_DUAL:
        begin
            dec_aln = `SFRP_LN2;
            dec_dln = `SFRP_LN2;
            case (sh_d[7:0])
                `SFRP_OP_FAST,
                `SFRP_OP_DOUT,
                `SFRP_OP_DIO:
                begin
                    dec_ok  = 1'b1;
                    dec_dum = `SFRP_DUM_DUAL;
                end
                `SFRP_OP_DISC:
                begin
                    dec_ok   = 1'b1;
                    dec_dum  = `SFRP_DUM_DISC;
                    dec_disc = 1'b1;
                end
                default: dec_ok = 1'b0;
            endcase
        end
        // quad accepts fast, quad out, quad io
        `SFRP_PROTO_QUAD:
        begin
            dec_aln = `SFRP_LN4;
            dec_dln = `SFRP_LN4;
            case (sh_d[7:0])
                `SFRP_OP_FAST,
                `SFRP_OP_QOUT,
                `SFRP_OP_QIO:
                begin
                    dec_ok  = 1'b1;
                    dec_dum = `SFRP_DUM_QUAD;
                end
                `SFRP_OP_DISC:
                begin
                    dec_ok   = 1'b1;
                    dec_dum  = `SFRP_DUM_DISCQ;
                    dec_disc = 1'b1;
                end
                default: dec_ok = 1'b0;
            endcase
        end
        default: dec_ok = 1'b0;
    endcase
    if (dec_ok && !dec_disc && dec_dum != `SFRP_DUM_NONE &&
        dummy_cfg != `SFRP_DUM_NONE)
        dec_dum = dummy_cfg;
end

// ==========================================================
// input shifter for opcode and address
// bits shifted in on detected rise
always @*
begin
    in_ln = state_q[2] ? aln_q : cln;
    case (in_ln)
        `SFRP_LN2: sh_d = {sh_q[21:0], dq_s[1:0]};
        `SFRP_LN4: sh_d = {sh_q[19:0], dq_s};
        default:   sh_d = {sh_q[22:0], dq_s[0]};
    endcase
    cnt_d = bit_cnt_q + {2'b00, in_ln};
    // next byte address, table reads wrap
    addr_nx = mem_addr + `SFRP_ADDR_ONE;
    if (disc_q)
        addr_nx = addr_nx & `SFRP_DISC_MASK;
end

// ==========================================================
// sequencer and output driver
always @(posedge clk or negedge rstn)
begin
    if (!rstn)
    begin
        state_q   <= ST_IDLE;
        sh_q      <= `SFRP_ADDR_ZERO;
        bit_cnt_q <= `SFRP_CNT_ZERO;
        aln_q     <= `SFRP_LN1;
        dln_q     <= `SFRP_LN1;
        dum_q     <= `SFRP_DUM_NONE;
        disc_q    <= 1'b0;
        buf_q     <= `SFRP_ERASED;
        fetch_q   <= 1'b0;
        out_sh_q  <= `SFRP_ERASED;
        left_q    <= 4'h0;
        dq_out    <= `SFRP_OE_OFF;
        dq_oe     <= `SFRP_OE_OFF;
        mem_addr  <= `SFRP_ADDR_ZERO;
        mem_rd    <= 1'b0;
    end
    else if (cs_s)
    begin
        // select high ends the frame, drive released
        state_q   <= ST_IDLE;
        bit_cnt_q <= `SFRP_CNT_ZERO;
        fetch_q   <= 1'b0;
        mem_rd    <= 1'b0;
        dq_oe     <= `SFRP_OE_OFF;
        dq_out    <= `SFRP_OE_OFF;
    end
    else
    begin
        mem_rd  <= 1'b0;
        fetch_q <= mem_rd;
        // fetched byte lands one cycle after the request
        if (fetch_q)
            buf_q <= disc_q ? rom_data : mem_data;
        case (state_q)
            ST_IDLE:
            begin
                state_q   <= ST_CMD;
                bit_cnt_q <= `SFRP_CNT_ZERO;
            end
            ST_CMD:
            begin
                if (rise)
                begin
                    sh_q      <= sh_d;
                    bit_cnt_q <= cnt_d;
                    if (cnt_d == `SFRP_CMD_BITS)
                    begin
                        bit_cnt_q <= `SFRP_CNT_ZERO;
                        aln_q     <= dec_aln;
                        dln_q     <= dec_dln;
                        dum_q     <= dec_dum;
                        disc_q    <= dec_disc;
                        // refused opcodes idle out the frame
                        state_q   <= dec_ok ? ST_ADDR : ST_SKIP;
                    end
                end
            end
            ST_ADDR:
            begin
                if (rise)
                begin
                    sh_q      <= sh_d;
                    bit_cnt_q <= cnt_d;
                    if (cnt_d == `SFRP_ADDR_BITS)
                    begin
                        bit_cnt_q <= `SFRP_CNT_ZERO;
                        left_q    <= 4'h0;
                        mem_addr  <= disc_q ? (sh_d & `SFRP_DISC_MASK)
                                            : sh_d;
                        mem_rd    <= 1'b1;
                        state_q   <= (dum_q == `SFRP_DUM_NONE) ?
                                     ST_DATA : ST_DUMMY;
                    end
                end
            end
            ST_DUMMY:
            begin
                if (rise)
                begin
                    dum_q <= dum_q - `SFRP_DUM_ONE;
                    if (dum_q == `SFRP_DUM_ONE)
                        state_q <= ST_DATA;
                end
            end
            ST_DATA:
            begin
                if (fall)
                begin
                    dq_oe <= oe_of(dln_q);
                    if (left_q == 4'h0)
                    begin
                        dq_out   <= out_grp(buf_q, dln_q);
                        out_sh_q <= buf_q << dln_q;
                        left_q   <= `SFRP_BYTE_BITS - {1'b0, dln_q};
                        mem_addr <= addr_nx;
                        mem_rd   <= 1'b1;
                    end
                    else
                    begin
                        dq_out   <= out_grp(out_sh_q, dln_q);
                        out_sh_q <= out_sh_q << dln_q;
                        left_q   <= left_q - {1'b0, dln_q};
                    end
                end
            end
            ST_SKIP:
                state_q <= ST_SKIP;
            default:
                state_q <= ST_IDLE;
        endcase
    end
end

endmodule // sfrp_top
